// ### cpt_pkg.sv
// Constants, decode helpers and types for the channel pattern test block
// Functional notes
// - Three 8-bit channel control registers, fixed addresses
// - Enable bit one starts generator and checker
// - Enable bit zero stops both; resets zero
// - DS3 or STS-1 rate sends 2^15-1 sequence
// - E3 rate sends 2^23-1 sequence
// - Checker hunts received data for matching sequence
// - Test mode replaces system transmit data
// - Single rail: negative output flags errors
// - Pattern test only in host register mode
// - Loop select bits choose loop-back mode
// - Rate bit two selects E3, bit one picks
package cpt_pkg;

  // ************************************************
  // Register map
  // ************************************************
  localparam int         ADDR_W     = 8;
  localparam int         DATA_W     = 8;
  localparam int         NUM_CH     = 3;
  localparam logic [7:0] CH0_CTRL   = 8'h06;
  localparam logic [7:0] CH1_CTRL   = 8'h0E;
  localparam logic [7:0] CH2_CTRL   = 8'h16;
  localparam logic [7:0] IRQ_STAT   = 8'h20;
  localparam logic [7:0] IRQ_MASK   = 8'h21;
  localparam logic [7:0] LOCK_STAT  = 8'h22;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h3F;
  localparam logic [5:0] STAT_RST   = 6'h00;
  localparam logic [1:0] CH_NONE    = 2'h3;

  // ************************************************
  // Control field positions
  // ************************************************
  localparam int BIT_RAIL = 0;
  localparam int BIT_STS  = 1;
  localparam int BIT_E3   = 2;
  localparam int BIT_LLB  = 3;
  localparam int BIT_RLB  = 4;
  localparam int BIT_PRBS = 5;

  // ************************************************
  // Sequence generator and checker
  // ************************************************
  localparam int          LFSR_W   = 23;
  localparam logic [22:0] LFSR_SEED = 23'h7F_FFFF;
  localparam int          TAP_S_A  = 14;
  localparam int          TAP_S_B  = 13;
  localparam int          TAP_E_A  = 22;
  localparam int          TAP_E_B  = 17;
  // Run length must exceed the register fill so garbage cannot lock
  localparam logic [5:0]  SYNC_RUN = 6'h30;

  typedef enum logic [1:0] {
    LOOP_NONE    = 2'b00,
    LOOP_REMOTE  = 2'b01,
    LOOP_ANALOG  = 2'b10,
    LOOP_DIGITAL = 2'b11
  } cpt_loop_e;

  typedef enum logic {
    CHK_HUNT = 1'b0,
    CHK_SYNC = 1'b1
  } cpt_chk_e;

  function automatic logic prbs_fb(input logic [22:0] sr,
                                   input logic        euro);
    prbs_fb = euro ? (sr[TAP_E_A] ^ sr[TAP_E_B])
                   : (sr[TAP_S_A] ^ sr[TAP_S_B]);
  endfunction

  function automatic logic [1:0] chan_of(input logic [7:0] a);
    case (a)
      CH0_CTRL: chan_of = 2'h0;
      CH1_CTRL: chan_of = 2'h1;
      CH2_CTRL: chan_of = 2'h2;
      default:  chan_of = CH_NONE;
    endcase
  endfunction

  function automatic cpt_loop_e loop_of(input logic [7:0] c);
    loop_of = cpt_loop_e'({c[BIT_LLB], c[BIT_RLB]});
  endfunction

endpackage

// ### cpt_prbs_lane.sv
// One channel of pattern generator and self-synchronising checker
`timescale 1ns/1ps
module cpt_prbs_lane (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic enable,
  input  wire logic euro,
  input  wire logic rx_bit,
  output logic      tx_bit,
  output logic      err,
  output logic      sync_gain,
  output logic      locked
);

  logic [22:0]     gen_sr;
  logic [22:0]     chk_sr;
  logic [5:0]      run;
  cpt_pkg::cpt_chk_e state;
  logic            gen_fb;
  logic            mis;

  assign gen_fb = cpt_pkg::prbs_fb(gen_sr, euro);
  assign mis    = rx_bit ^ cpt_pkg::prbs_fb(chk_sr, euro);
  assign locked = (state == cpt_pkg::CHK_SYNC);

  // ************************************************
  // Generator
  // ************************************************
  always_ff @(posedge clk) begin
    if (!rst_b || !enable) begin
      gen_sr <= cpt_pkg::LFSR_SEED;
      tx_bit <= 1'b0;
    end else begin
      gen_sr <= {gen_sr[21:0], gen_fb};
      tx_bit <= gen_fb;
    end
  end

  // ************************************************
  // Checker
  // ************************************************
  always_ff @(posedge clk) begin
    if (!rst_b || !enable) begin
      chk_sr    <= cpt_pkg::LFSR_SEED;
      run       <= 6'h00;
      state     <= cpt_pkg::CHK_HUNT;
      err       <= 1'b0;
      sync_gain <= 1'b0;
    end else begin
      chk_sr    <= {chk_sr[21:0], rx_bit};
      err       <= 1'b0;
      sync_gain <= 1'b0;
      case (state)
        cpt_pkg::CHK_HUNT: begin
          if (mis) begin
            run <= 6'h00;
          end else if (run == cpt_pkg::SYNC_RUN - 6'h01) begin
            state     <= cpt_pkg::CHK_SYNC;
            sync_gain <= 1'b1;
          end else begin
            run <= run + 6'h01;
          end
        end
        cpt_pkg::CHK_SYNC: begin
          err <= mis;
        end
        default: begin
          state <= cpt_pkg::CHK_HUNT;
        end
      endcase
    end
  end

  chk_gen_step: assert property (@(posedge clk) disable iff (!rst_b)
    enable && $past(enable) |->
      tx_bit == cpt_pkg::prbs_fb($past(gen_sr), $past(euro)))
    else $error("generator step wrong");

  chk_err_synced: assert property (@(posedge clk) disable iff (!rst_b)
    err |-> $past(state) == cpt_pkg::CHK_SYNC && $past(mis))
    else $error("error pulse outside sync");

  chk_off_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    !$past(enable) |-> !tx_bit && !err && !locked)
    else $error("lane active while disabled");

endmodule // cpt_prbs_lane

// ### cpt_top.sv
// Channel control registers and pattern test datapath, three channels
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module cpt_top (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  input  wire logic       host_mode,
  input  wire logic [2:0] tx_positive_data_in,
  input  wire logic [2:0] tx_negative_data_in,
  input  wire logic [2:0] rx_pos_in,
  input  wire logic [2:0] rx_neg_in,
  output logic      [2:0] line_pos_out,
  output logic      [2:0] line_neg_out,
  output logic      [2:0] rx_pos_out,
  output logic      [2:0] rx_negative_or_error_out,
  output logic            irq
);

  // ************************************************
  // Declarations
  // ************************************************
  logic [7:0] ctrl [cpt_pkg::NUM_CH];
  logic [5:0] stat;
  logic [5:0] mask;
  logic [5:0] next_stat;

  logic [2:0] txp_m;
  logic [2:0] txp_q;
  logic [2:0] txn_m;
  logic [2:0] txn_q;
  logic [2:0] rxp_m;
  logic [2:0] rxp_q;
  logic [2:0] rxn_m;
  logic [2:0] rxn_q;
  logic       host_m;
  logic       host_q;

  wire  [2:0] en_f;
  wire  [2:0] rail_f;
  wire  [2:0] e3_f;
  wire  [2:0] rem_f;
  wire  [2:0] loc_f;
  wire  [2:0] gen_bit;
  wire  [2:0] lane_err;
  wire  [2:0] lane_gain;
  wire  [2:0] lane_lock;

  logic [2:0] act;
  logic [2:0] src_p;
  logic [2:0] src_n;
  logic [2:0] rx_p;
  logic [2:0] rx_n;
  logic [1:0] rd_ch;

  // ************************************************
  // Pin synchronisers
  // ************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txp_m  <= 3'h0;
      txp_q  <= 3'h0;
      txn_m  <= 3'h0;
      txn_q  <= 3'h0;
      rxp_m  <= 3'h0;
      rxp_q  <= 3'h0;
      rxn_m  <= 3'h0;
      rxn_q  <= 3'h0;
      host_m <= 1'b0;
      host_q <= 1'b0;
    end else begin
      txp_m  <= tx_positive_data_in;
      txp_q  <= txp_m;
      txn_m  <= tx_negative_data_in;
      txn_q  <= txn_m;
      rxp_m  <= rx_pos_in;
      rxp_q  <= rxp_m;
      rxn_m  <= rx_neg_in;
      rxn_q  <= rxn_m;
      host_m <= host_mode;
      host_q <= host_m;
    end
  end

  // ************************************************
  // Control registers
  // ************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < cpt_pkg::NUM_CH; i++) begin
        ctrl[i] <= cpt_pkg::CTRL_RST;
      end
    end else begin
      for (int i = 0; i < cpt_pkg::NUM_CH; i++) begin
        // Unused top bits are never stored
        if (wr_en && cpt_pkg::chan_of(addr) == 2'(i)) begin
          ctrl[i] <= wr_data & cpt_pkg::CTRL_WMASK;
        end
      end
    end
  end

  // ************************************************
  // Per-channel fields and pattern lanes
  // ************************************************
  for (genvar g = 0; g < cpt_pkg::NUM_CH; g++) begin : g_ch
    assign en_f[g]   = ctrl[g][cpt_pkg::BIT_PRBS];
    assign rail_f[g] = ctrl[g][cpt_pkg::BIT_RAIL];
    assign e3_f[g]   = ctrl[g][cpt_pkg::BIT_E3];
    assign rem_f[g]  = cpt_pkg::loop_of(ctrl[g]) ==
                       cpt_pkg::LOOP_REMOTE;
    assign loc_f[g]  = ctrl[g][cpt_pkg::BIT_LLB];

    cpt_prbs_lane u_lane (
      .clk       (clk),
      .rst_b     (rst_b),
      .enable    (act[g]),
      .euro      (e3_f[g]),
      .rx_bit    (rx_p[g]),
      .tx_bit    (gen_bit[g]),
      .err       (lane_err[g]),
      .sync_gain (lane_gain[g]),
      .locked    (lane_lock[g])
    );
  end

  // ************************************************
  // Datapath selection
  // ************************************************
  always_comb begin
    // Strap mode still stores register writes, but runs no test
    act   = en_f & {3{host_q}};
    src_p = (act & gen_bit) | (~act & txp_q);
    src_n = ~act & txn_q;
    // Both local loops feed transmit back inward
    rx_p  = (loc_f & src_p) | (~loc_f & rxp_q);
    rx_n  = (loc_f & src_n) | (~loc_f & rxn_q);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      line_pos_out             <= 3'h0;
      line_neg_out             <= 3'h0;
      rx_pos_out               <= 3'h0;
      rx_negative_or_error_out <= 3'h0;
    end else begin
      line_pos_out <= (rem_f & rxp_q) | (~rem_f & src_p);
      line_neg_out <= (rem_f & rxn_q) | (~rem_f & src_n);
      rx_pos_out   <= rx_p;
      // Errors are only pulses; counting is left outside
      rx_negative_or_error_out <= (~rail_f & act & lane_err) |
                                  (rail_f & rx_n);
    end
  end

  // ************************************************
  // Interrupt status and mask
  // ************************************************
  always_comb begin
    next_stat = stat;
    if (wr_en && addr == cpt_pkg::IRQ_STAT) begin
      next_stat = stat & ~wr_data[5:0];
    end
    // Set after clear so a same-cycle event survives
    next_stat = next_stat | {lane_gain, lane_err & act};
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stat <= cpt_pkg::STAT_RST;
    end else begin
      stat <= next_stat;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mask <= cpt_pkg::STAT_RST;
    end else if (wr_en && addr == cpt_pkg::IRQ_MASK) begin
      mask <= wr_data[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_stat & mask);
    end
  end

  // ************************************************
  // Read port
  // ************************************************
  assign rd_ch = cpt_pkg::chan_of(addr);

  always_ff @(posedge clk) begin
    if (!rst_b || !rd_en) begin
      rd_data <= 8'h00;
    end else if (rd_ch != cpt_pkg::CH_NONE) begin
      rd_data <= ctrl[rd_ch];
    end else begin
      case (addr)
        cpt_pkg::IRQ_STAT:  rd_data <= {2'h0, stat};
        cpt_pkg::IRQ_MASK:  rd_data <= {2'h0, mask};
        cpt_pkg::LOCK_STAT: rd_data <= {5'h00, lane_lock};
        default:            rd_data <= 8'h00;
      endcase
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  chk_ctrl_write: assert property (@(posedge clk) disable iff (!rst_b)
    wr_en && addr == cpt_pkg::CH1_CTRL |=>
      ctrl[1] == ($past(wr_data) & cpt_pkg::CTRL_WMASK))
    else $error("channel control write lost");

  chk_tx_override: assert property (@(posedge clk) disable iff (!rst_b)
    act[0] && !rem_f[0] |=>
      line_pos_out[0] == $past(gen_bit[0]) && !line_neg_out[0])
    else $error("system data not replaced");

  chk_tx_pass: assert property (@(posedge clk) disable iff (!rst_b)
    !en_f[0] && !rem_f[0] |=>
      line_pos_out[0] == $past(txp_q[0]))
    else $error("system data not passed");

  chk_err_pin: assert property (@(posedge clk) disable iff (!rst_b)
    act[2] && !rail_f[2] |=>
      rx_negative_or_error_out[2] == $past(lane_err[2]))
    else $error("error pin not following checker");

  chk_strap_gate: assert property (@(posedge clk) disable iff (!rst_b)
    !host_q && !rail_f[1] |=> !rx_negative_or_error_out[1])
    else $error("test active in strap mode");

  chk_remote_loop: assert property (@(posedge clk) disable iff (!rst_b)
    rem_f[0] |=> line_pos_out[0] == $past(rxp_q[0]))
    else $error("remote loop not applied");

  chk_rd_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    !rd_en |=> rd_data == 8'h00)
    else $error("read data outside its cycle");

  chk_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 irq == |($past(next_stat) & $past(mask)))
    else $error("interrupt level wrong");

endmodule // cpt_top

// ### cpt_sys_model.sv
// System-side terminal model: random tx rails, counts error pulses
`timescale 1ns/1ps
module cpt_sys_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] err_in,
  output logic      [2:0] tx_pos,
  output logic      [2:0] tx_neg,
  output int              err_tot
);
  int seed = 32'he910;
  // Fresh data every bit, so a stale or passed-through rail shows
  always @(posedge clk) begin
    if (!rst_b) begin
      tx_pos <= 3'h0;
      tx_neg <= 3'h0;
    end else begin
      tx_pos <= 3'($random(seed));
      tx_neg <= 3'($random(seed));
    end
  end
  // Device holds no count, so the glue logic keeps it
  always @(posedge clk) begin
    if (!rst_b) begin
      err_tot <= 0;
    end else begin
      err_tot <= err_tot + err_in[0] + err_in[1] + err_in[2];
    end
  end
endmodule // cpt_sys_model

// ### channel_prbs_test_control_tb_top.sv
// Self-checking bench for the channel pattern test block
`timescale 1ns/1ps
module channel_prbs_test_control_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wr_data = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        host_mode = 1'b1;
  logic        lpbk = 1'b0;
  logic [2:0]  rx_pos = 3'h0;
  logic [2:0]  rx_neg = 3'h0;
  logic [2:0]  inj = 3'h0;
  logic [8:0]  h_tx = '0;
  logic [8:0]  h_rx = '0;
  logic [8:0]  h_rn = '0;
  logic [22:0] seq = '0;
  logic [7:0]  rd_data;
  logic [2:0]  tx_pos, tx_neg, line_pos, line_neg, rx_out, rx_err;
  logic        irq;
  logic [7:0]  rv [0:2];
  logic [7:0]  ca [0:2] = '{8'h06, 8'h0E, 8'h16};
  logic [7:0]  lp [0:3] = '{8'h00, 8'h10, 8'h08, 8'h18};
  int          md [0:3] = '{1, 2, 3, 3};
  int          err_count = 0;
  int          cmp_count = 0;
  int          seed = 32'he910;
  int          cyc = 0;
  int          mon = 0;
  int          nb = 0;
  int          tch = 0;
  int          base;
  int          err_tot;

  always #5 clk = ~clk;

  cpt_top dut_u (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .host_mode(host_mode), .tx_positive_data_in(tx_pos),
    .tx_negative_data_in(tx_neg), .rx_pos_in(rx_pos),
    .rx_neg_in(rx_neg), .line_pos_out(line_pos),
    .line_neg_out(line_neg), .rx_pos_out(rx_out),
    .rx_negative_or_error_out(rx_err), .irq(irq));

  cpt_sys_model sys_u (
    .clk(clk), .rst_b(rst_b), .err_in(rx_err), .tx_pos(tx_pos),
    .tx_neg(tx_neg), .err_tot(err_tot));

  task automatic results();
    $display("Compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk("rd_data", e, rd_data);
  endtask

  // ****************************************
  // Line side, histories and timeout
  // ****************************************
  // Loop-back feeds the checker; inj flips single received bits
  always @(posedge clk) begin
    rx_pos <= lpbk ? (line_pos ^ inj) : 3'($random(seed));
    rx_neg <= 3'($random(seed));
    h_tx <= {h_tx[5:0], tx_pos};
    h_rx <= {h_rx[5:0], rx_pos};
    h_rn <= {h_rn[5:0], rx_neg};
    seq <= {seq[21:0], line_pos[tch]};
    nb <= (mon == 4 || mon == 5) ? nb + 1 : 0;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      results();
    end
  end

  always @(negedge clk) begin
    if (mon == 1) begin
      chk("normal", {2'h0, h_tx[8:6], h_rx[8:6]}, {2'h0, line_pos, rx_out});
      chk("err pin idle", 8'h00, {5'h0, rx_err});
    end
    if (mon == 2) chk("remote", {5'h0, h_rx[8:6]}, {5'h0, line_pos});
    if (mon == 3) chk("local", {5'h0, h_tx[8:6]}, {5'h0, rx_out});
    if (mon == 4 && nb > 30) chk("seq15", {7'h0, seq[14] ^ seq[13]}, {7'h0, line_pos[tch]});
    if (mon == 5 && nb > 30) chk("seq23", {7'h0, seq[22] ^ seq[17]}, {7'h0, line_pos[tch]});
    // First bit after the enable write still carries system data
    if ((mon == 4 || mon == 5) && nb > 1) chk("neg rail", 8'h00, {7'h0, line_neg[tch]});
    if (mon == 6) chk("dual rail", {7'h0, h_rn[6 + tch]}, {7'h0, rx_err[tch]});
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 3; i++) rd(ca[i], 8'h00);
    rd(8'h07, 8'h00);
    for (int i = 0; i < 3; i++) begin
      rv[i] = 8'($random(seed)) & 8'hDF;
      wr(ca[i], rv[i]);
    end
    for (int i = 0; i < 3; i++) rd(ca[i], rv[i] & 8'h1F);
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 3; i++) wr(ca[i], lp[m]);
      repeat (5) @(posedge clk);
      mon = md[m];
      repeat (20) @(posedge clk);
      mon = 0;
    end
    // Strap low: enable bit is stored but the test must stay off
    host_mode <= 1'b0;
    for (int i = 0; i < 3; i++) wr(ca[i], 8'h20);
    repeat (5) @(posedge clk);
    mon = 1;
    repeat (20) @(posedge clk);
    mon = 0;
    host_mode <= 1'b1;
    for (int i = 0; i < 3; i++) wr(ca[i], 8'h00);
    lpbk <= 1'b1;
    wr(8'h21, 8'h07);
    for (int t = 0; t < 3; t++) begin
      tch = t;
      base = err_tot;
      wr(ca[t], (t == 1) ? 8'h24 : ((t == 2) ? 8'h22 : 8'h20));
      mon = (t == 1) ? 5 : 4;
      repeat (150) @(posedge clk);
      chk("ones", 8'h01, {7'h0, |seq});
      mon = 0;
      rd(8'h22, 8'h01 << t);
      rd(8'h20, 8'h08 << t);
      chk("no errors", 8'h00, 8'(err_tot - base));
      chk("irq masked", 8'h00, {7'h0, irq});
      @(posedge clk);
      inj[t] <= 1'b1;
      @(posedge clk);
      inj <= 3'h0;
      repeat (40) @(posedge clk);
      chk("err count", 8'h01, {7'h0, err_tot > base});
      rd(8'h20, 8'h09 << t);
      chk("irq raised", 8'h01, {7'h0, irq});
      wr(8'h20, 8'h3F);
      @(negedge clk);
      chk("irq cleared", 8'h00, {7'h0, irq});
      wr(ca[t], (t == 1) ? 8'h25 : 8'h21);
      repeat (5) @(posedge clk);
      mon = 6;
      repeat (20) @(posedge clk);
      mon = 0;
      wr(ca[t], 8'h00);
      repeat (5) @(posedge clk);
      rd(8'h22, 8'h00);
      mon = 1;
      repeat (20) @(posedge clk);
      mon = 0;
    end
    results();
  end
endmodule // channel_prbs_test_control_tb_top
